// File: tecc_pkg.sv
// tecc_pkg: constants shared by the timer/event counter control block.
// assumes an 8-bit register port with a 3-bit word address.
package tecc_pkg;
    // ************************************************************
    // bus geometry
    // ************************************************************
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int IRQ_W = 4;
    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [2:0] OFF_T0_CTRL = 3'h0;
    localparam logic [2:0] OFF_T0_CNT = 3'h1;
    localparam logic [2:0] OFF_T1_CTRL = 3'h2;
    localparam logic [2:0] OFF_T1_CNT = 3'h3;
    localparam logic [2:0] OFF_IRQ_STS = 3'h4;
    localparam logic [2:0] OFF_IRQ_MSK = 3'h5;
    // ************************************************************
    // control register fields
    // ************************************************************
    localparam int CTL_MODE_HI = 7;
    localparam int CTL_MODE_LO = 6;
    localparam int CTL_SRC = 5;
    localparam int CTL_RUN = 4;
    localparam int CTL_EDGE = 3;
    localparam int CTL_PSC_HI = 2;
    localparam int CTL_PSC_LO = 0;
    localparam logic [7:0] T1_IMPL_MASK = 8'hF8;
    // ************************************************************
    // reset values and counts
    // ************************************************************
    localparam logic [7:0] CTRL_RST = 8'h08;
    localparam logic [7:0] CNT_RST = 8'h00;
    localparam logic [7:0] FULL_COUNT = 8'hFF;
    localparam logic [1:0] DIV4_LAST = 2'h3;
    // ************************************************************
    // mode codes and interrupt bits
    // ************************************************************
    localparam logic [1:0] MODE_NONE = 2'h0;
    localparam logic [1:0] MODE_EVT = 2'h1;
    localparam logic [1:0] MODE_TMR = 2'h2;
    localparam logic [1:0] MODE_PWC = 2'h3;
    localparam int IRQ_OVF0 = 0;
    localparam int IRQ_OVF1 = 1;
    localparam int IRQ_CAP0 = 2;
    localparam int IRQ_CAP1 = 3;
endpackage

// File: tecc_tmr_if.sv
// tecc_tmr_if: control and status bundle between the register block and one counter.
// assumes both ends run on sys_clk_i.
`timescale 1ns/1ps
interface tecc_tmr_if;
    logic [7:0] ctrl;
    logic int_tick;
    logic pin_rise;
    logic pin_fall;
    logic pre_we;
    logic [7:0] pre_data;
    logic [7:0] count;
    logic ovf;
    logic stop;
    modport ctl (output ctrl, int_tick, pin_rise, pin_fall, pre_we, pre_data,
                 input count, ovf, stop);
    modport tmr (input ctrl, int_tick, pin_rise, pin_fall, pre_we, pre_data,
                 output count, ovf, stop);
endinterface

// File: tecc_prescale.sv
// tecc_prescale: power-of-two divider of an internal count tick.
// assumes tick_i is a one-cycle pulse on sys_clk_i.
`timescale 1ns/1ps
module tecc_prescale
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    // tick in, ratio code, tick out
    input wire logic tick_i,
    input wire logic [2:0] psc_code_i,
    output logic tick_o
);
    import tecc_pkg::*;
    logic [7:0] div_reg;
    logic [7:0] div_next;

    // low bits that must all be ones for a divided tick
    function automatic logic [7:0] psc_mask(input logic [2:0] code);
        psc_mask = 8'(({1'b0, 8'h01} << (4'(code) + 4'h1)) - 9'h001);
    endfunction

    // RULE_14: code n divides by 2 to the n+1
    always_comb
    begin
        div_next = tick_i ? 8'(div_reg + 8'h01) : div_reg;
        tick_o = tick_i && ((div_reg & psc_mask(psc_code_i)) == psc_mask(psc_code_i));
    end

    // free running; a ratio change takes effect at once
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
            div_reg <= CNT_RST;
        else if (clk_en_i)
            div_reg <= div_next;
    end
endmodule // tecc_prescale

// File: tecc_timer.sv
// tecc_timer: one 8-bit count-up counter with its three modes.
// assumes pin edges come already synchronised as one-cycle pulses.
`timescale 1ns/1ps
module tecc_timer
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    // control and status
    tecc_tmr_if.tmr tb
);
    import tecc_pkg::*;
    typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_MEAS} tecc_pwc_t;
    tecc_pwc_t st_reg;
    tecc_pwc_t st_next;
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    logic [7:0] pre_reg;
    logic [7:0] pre_next;
    logic [1:0] mode;
    logic run;
    logic edge_sel;
    logic act_edge;
    logic start_edge;
    logic stop_edge;
    logic adv;
    logic ovf;
    logic stop;

    // ************************************************************
    // field decode and pin edge choice
    // ************************************************************
    // RULE_01: mode from the top two control bits
    always_comb
    begin
        mode = tb.ctrl[CTL_MODE_HI:CTL_MODE_LO];
        run = tb.ctrl[CTL_RUN];
        edge_sel = tb.ctrl[CTL_EDGE];
        // RULE_06: edge select for event counting
        act_edge = edge_sel ? tb.pin_fall : tb.pin_rise;
        // RULE_07: capture start and stop edges
        start_edge = edge_sel ? tb.pin_rise : tb.pin_fall;
        stop_edge = edge_sel ? tb.pin_fall : tb.pin_rise;
    end

    // ************************************************************
    // pulse width capture sequencing
    // ************************************************************
    always_comb
    begin
        st_next = st_reg;
        stop = 1'b0;
        case (st_reg)
            ST_IDLE:
                if (run && mode == MODE_PWC)
                    st_next = ST_ARMED;
            ST_ARMED:
                if (!run || mode != MODE_PWC)
                    st_next = ST_IDLE;
                else if (start_edge)
                    st_next = ST_MEAS;
            ST_MEAS:
                if (!run || mode != MODE_PWC)
                    st_next = ST_IDLE;
                // RULE_13: pin back at its level stops the run
                else if (stop_edge)
                begin
                    stop = 1'b1;
                    st_next = ST_IDLE;
                end
            default:
                st_next = ST_IDLE;
        endcase
    end

    // ************************************************************
    // counter, preload and overflow
    // ************************************************************
    always_comb
    begin
        // RULE_02: mode pair decoding
        case (mode)
            // RULE_05: pin edges counted undivided
            MODE_EVT: adv = run && act_edge;
            MODE_TMR: adv = run && tb.int_tick;
            MODE_PWC: adv = run && st_reg == ST_MEAS && tb.int_tick;
            // RULE_15: no mode, no counting
            default: adv = 1'b0;
        endcase
        pre_next = tb.pre_we ? tb.pre_data : pre_reg;
        cnt_next = cnt_reg;
        ovf = 1'b0;
        // RULE_03: run bit gates every advance
        if (adv)
        begin
            // RULE_11: overflow past full reloads
            if (cnt_reg == FULL_COUNT)
            begin
                cnt_next = pre_reg;
                ovf = 1'b1;
            end
            else
                cnt_next = 8'(cnt_reg + 8'h01);
        end
        // RULE_12: stopped timer takes the preload at once
        if (tb.pre_we && !run)
            cnt_next = tb.pre_data;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            st_reg <= ST_IDLE;
            cnt_reg <= CNT_RST;
            pre_reg <= CNT_RST;
        end
        else if (clk_en_i)
        begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            pre_reg <= pre_next;
        end
    end

    assign tb.count = cnt_reg;
    assign tb.ovf = ovf && clk_en_i;
    assign tb.stop = stop && clk_en_i;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (reset_i);

    sequence s_arm_start;
        clk_en_i && run && mode == MODE_PWC && st_reg == ST_ARMED && start_edge;
    endsequence
    sequence s_meas_stop;
        clk_en_i && st_reg == ST_MEAS && run && mode == MODE_PWC && stop_edge;
    endsequence

    a_ovf_reload: assert property ( // RULE_11
        clk_en_i && adv && cnt_reg == FULL_COUNT && !(tb.pre_we && !run)
        |-> ovf ##1 cnt_reg == $past(pre_reg))
        else $error("overflow did not reload preload");
    a_run_halt: assert property ( // RULE_03
        clk_en_i && !run && !tb.pre_we |=> $stable(cnt_reg))
        else $error("counter moved while stopped");
    a_mode_none: assert property ( // RULE_15
        clk_en_i && mode == MODE_NONE && !tb.pre_we |=> $stable(cnt_reg))
        else $error("counter moved with no mode");
    a_stop_load: assert property ( // RULE_12
        clk_en_i && tb.pre_we && !run |=> cnt_reg == $past(tb.pre_data))
        else $error("stopped preload not loaded");
    a_run_defer: assert property ( // RULE_12
        clk_en_i && tb.pre_we && run && !adv |=> $stable(cnt_reg) && pre_reg == $past(tb.pre_data))
        else $error("running preload reached counter");
    a_evt_edge: assert property ( // RULE_06
        clk_en_i && run && mode == MODE_EVT && act_edge && cnt_reg != FULL_COUNT
        |=> cnt_reg == $past(cnt_reg) + 8'h01)
        else $error("event edge not counted");
    a_pwc_start: assert property ( // RULE_07
        s_arm_start |=> st_reg == ST_MEAS)
        else $error("capture did not start on edge");
    a_pwc_stop: assert property ( // RULE_13
        s_meas_stop |-> tb.stop ##1 st_reg == ST_IDLE)
        else $error("capture did not stop on edge");
endmodule // tecc_timer

// File: tecc_top.sv
// tecc_top: register port, pin synchronisers, clock sources and interrupt
// for two 8-bit timer/event counters.
// assumes a single-cycle register master on sys_clk_i and asynchronous pins.
//
// Overview of operation
// RULE_01: each timer's mode comes from control bits 7 and 6.
// RULE_02: mode 01 events, 10 interval timer, 11 pulse capture, 00 none.
// RULE_03: control bit 4 runs the counter; zero halts it.
// RULE_04: timer 0 internal clock divided by ratio in control bits 2 to 0.
// RULE_05: pin-clocked counting ignores the prescaler, one count per edge.
// RULE_06: event mode edge bit 3: zero rising, one falling.
// RULE_07: capture edge bit zero: start falling, stop rising; one reverses.
// RULE_08: timer 1 bit 5: zero system clock over four, one crystal.
// RULE_09: timer 1 low three control bits absent, read as zero.
// RULE_10: timer 0 bit 5: zero system clock, one low-speed crystal.
// RULE_11: count up from preload; past FFH overflow, interrupt, reload, continue.
// RULE_12: preload write loads counter if stopped, else waits for overflow.
// RULE_13: capture clears run bit at end; pin ignored until rerun.
// RULE_14: prescaler code 000 divides by 2, each step doubles.
// RULE_15: mode 00 never advances the counter, whatever the run bit.
`timescale 1ns/1ps
module tecc_top
(
    // clock, reset, enable
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    // register port
    input wire logic [tecc_pkg::ADDR_W-1:0] addr_i,
    input wire logic [tecc_pkg::DATA_W-1:0] wr_data_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    output logic [tecc_pkg::DATA_W-1:0] rd_data_o,
    // pins
    input wire logic [1:0] timer_input_pin_i,
    input wire logic low_speed_crystal_i,
    // interrupt
    output logic irq_o
);
    import tecc_pkg::*;

    // ************************************************************
    // declarations
    // ************************************************************
    logic [2:0] sy1_reg;
    logic [2:0] sy1_next;
    logic [2:0] sy2_reg;
    logic [2:0] sy2_next;
    logic [2:0] prv_reg;
    logic [2:0] prv_next;
    logic [2:0] rise;
    logic [2:0] fall;
    logic [1:0] d4_reg;
    logic [1:0] d4_next;
    logic lxt_tick;
    logic src0_tick;
    logic [1:0] int_tick;
    logic [7:0] ctl0_reg;
    logic [7:0] ctl0_next;
    logic [7:0] ctl1_reg;
    logic [7:0] ctl1_next;
    logic [IRQ_W-1:0] sts_reg;
    logic [IRQ_W-1:0] sts_next;
    logic [IRQ_W-1:0] msk_reg;
    logic [IRQ_W-1:0] msk_next;
    logic [IRQ_W-1:0] evt;
    logic [7:0] rd_next;
    logic irq_next;
    logic [7:0] cnt_w [2];
    logic [1:0] ovf_w;
    logic [1:0] stop_w;
    logic [1:0] pre_we;
    logic [7:0] ctl_w [2];

    // write strobe decode, used for several registers
    function automatic logic wr_hit(input logic en, input logic [2:0] a, input logic [2:0] off);
        wr_hit = en && a == off;
    endfunction

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    // two stages before any logic; the third stage only feeds edge detect
    always_comb
    begin
        sy1_next = {low_speed_crystal_i, timer_input_pin_i};
        sy2_next = sy1_reg;
        prv_next = sy2_reg;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            sy1_reg <= 3'h0;
            sy2_reg <= 3'h0;
            prv_reg <= 3'h0;
        end
        else if (clk_en_i)
        begin
            sy1_reg <= sy1_next;
            sy2_reg <= sy2_next;
            prv_reg <= prv_next;
        end
    end

    // edges seen at the synchroniser output, against the third stage
    always_comb
    begin
        rise = sy2_reg & ~prv_reg;
        fall = ~sy2_reg & prv_reg;
    end

    // ************************************************************
    // internal count sources
    // ************************************************************
    // crystal is sampled, so it must run well below a quarter of sys_clk_i
    always_comb
    begin
        d4_next = 2'(d4_reg + 2'h1);
        lxt_tick = rise[2];
        // RULE_10: timer 0 picks system clock or crystal
        src0_tick = ctl0_reg[CTL_SRC] ? lxt_tick : 1'b1;
    end

    // RULE_08: timer 1 picks system clock over four or crystal
    assign int_tick[1] = ctl1_reg[CTL_SRC] ? lxt_tick : d4_reg == DIV4_LAST;

    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
            d4_reg <= 2'h0;
        else if (clk_en_i)
            d4_reg <= d4_next;
    end

    // RULE_04: only timer 0 has a prescaler
    tecc_prescale u_psc0
    (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .clk_en_i(clk_en_i),
        .tick_i(src0_tick),
        .psc_code_i(ctl0_reg[CTL_PSC_HI:CTL_PSC_LO]),
        .tick_o(int_tick[0])
    );

    // ************************************************************
    // counters
    // ************************************************************
    assign ctl_w[0] = ctl0_reg;
    assign ctl_w[1] = ctl1_reg;

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_tmr
            tecc_tmr_if tif ();
            assign tif.ctrl = ctl_w[g];
            assign tif.int_tick = int_tick[g];
            assign tif.pin_rise = rise[g];
            assign tif.pin_fall = fall[g];
            assign tif.pre_we = pre_we[g];
            assign tif.pre_data = wr_data_i;
            assign cnt_w[g] = tif.count;
            assign ovf_w[g] = tif.ovf;
            assign stop_w[g] = tif.stop;
            tecc_timer u_tmr
            (
                .sys_clk_i(sys_clk_i),
                .reset_i(reset_i),
                .clk_en_i(clk_en_i),
                .tb(tif.tmr)
            );
        end
    endgenerate

    // ************************************************************
    // control registers
    // ************************************************************
    // a software write in the stop cycle wins: it is a fresh rerun
    always_comb
    begin
        pre_we[0] = wr_hit(wr_en_i, addr_i, OFF_T0_CNT);
        pre_we[1] = wr_hit(wr_en_i, addr_i, OFF_T1_CNT);
        ctl0_next = ctl0_reg;
        ctl1_next = ctl1_reg;
        // RULE_13: capture end clears the run bit
        if (stop_w[0])
            ctl0_next[CTL_RUN] = 1'b0;
        if (stop_w[1])
            ctl1_next[CTL_RUN] = 1'b0;
        if (wr_hit(wr_en_i, addr_i, OFF_T0_CTRL))
            ctl0_next = wr_data_i;
        // RULE_09: timer 1 keeps only the upper five bits
        if (wr_hit(wr_en_i, addr_i, OFF_T1_CTRL))
            ctl1_next = wr_data_i & T1_IMPL_MASK;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            ctl0_reg <= CTRL_RST;
            ctl1_reg <= CTRL_RST;
        end
        else if (clk_en_i)
        begin
            ctl0_reg <= ctl0_next;
            ctl1_reg <= ctl1_next;
        end
    end

    // ************************************************************
    // interrupt status and mask
    // ************************************************************
    // a new event in the clearing cycle survives the clear
    always_comb
    begin
        evt = '0;
        // RULE_11: overflow raises a request
        evt[IRQ_OVF0] = ovf_w[0];
        evt[IRQ_OVF1] = ovf_w[1];
        evt[IRQ_CAP0] = stop_w[0];
        evt[IRQ_CAP1] = stop_w[1];
        sts_next = sts_reg;
        msk_next = msk_reg;
        if (wr_hit(wr_en_i, addr_i, OFF_IRQ_STS))
            sts_next = sts_reg & ~wr_data_i[IRQ_W-1:0];
        sts_next = sts_next | evt;
        if (wr_hit(wr_en_i, addr_i, OFF_IRQ_MSK))
            msk_next = wr_data_i[IRQ_W-1:0];
        irq_next = |(sts_next & msk_next);
    end

    // ************************************************************
    // read data
    // ************************************************************
    // data stand only in the cycle after the strobe; unmapped reads give zero
    always_comb
    begin
        rd_next = 8'h00;
        if (rd_en_i)
        begin
            case (addr_i)
                OFF_T0_CTRL: rd_next = ctl0_reg;
                OFF_T0_CNT: rd_next = cnt_w[0];
                OFF_T1_CTRL: rd_next = ctl1_reg & T1_IMPL_MASK;
                OFF_T1_CNT: rd_next = cnt_w[1];
                OFF_IRQ_STS: rd_next = 8'(sts_reg);
                OFF_IRQ_MSK: rd_next = 8'(msk_reg);
                default: rd_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            sts_reg <= '0;
            msk_reg <= '0;
            irq_o <= 1'b0;
            rd_data_o <= 8'h00;
        end
        else if (clk_en_i)
        begin
            sts_reg <= sts_next;
            msk_reg <= msk_next;
            irq_o <= irq_next;
            rd_data_o <= rd_next;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (reset_i);

    a_run_autoclr: assert property ( // RULE_13
        stop_w[0] && !wr_hit(wr_en_i, addr_i, OFF_T0_CTRL) |=> !ctl0_reg[CTL_RUN])
        else $error("capture end left run bit set");
    a_t1_low_zero: assert property ( // RULE_09
        clk_en_i && rd_en_i && addr_i == OFF_T1_CTRL |=> rd_data_o[2:0] == 3'h0)
        else $error("timer 1 low bits not zero");
    a_ovf_sticky: assert property ( // RULE_11
        ovf_w[0] |=> sts_reg[IRQ_OVF0] [*2] or (sts_reg[IRQ_OVF0] ##1 1'b1))
        else $error("overflow status not set");
    a_irq_level: assert property ( // RULE_11
        clk_en_i |=> irq_o == |(sts_reg & msk_reg))
        else $error("interrupt level mismatch");
endmodule // tecc_top

// File: tecc_pin_model.sv
// tecc_pin_model: far-side model driving both timer pins and the crystal.
// assumes pins change only just after sys_clk_i edges; the crystal toggles on every 8th of them.
`timescale 1ns/1ps
module tecc_pin_model
#(
    parameter int LXT_HALF = 8
)
(
    // clock
    input wire logic sys_clk_i,
    // levels toward the block
    output logic [1:0] pin_o,
    output logic lxt_o
);
    // ************************************************************
    // crystal and pins
    // ************************************************************
    int lxt_cnt = 0;
    // idle levels at time zero
    initial
    begin
        pin_o = 2'h0;
        lxt_o = 1'b0;
    end
    // crystal kept in step with sys_clk_i so tick counts over a window are exact
    always @(posedge sys_clk_i)
    begin
        lxt_cnt <= (lxt_cnt == LXT_HALF - 1) ? 0 : lxt_cnt + 1;
        if (lxt_cnt == LXT_HALF - 1)
        begin
            lxt_o <= ~lxt_o;
        end
    end
    // one level change, launched just after an edge
    task automatic set_pin(input int ch, input logic v);
        @(posedge sys_clk_i);
        pin_o[ch] <= v;
    endtask
    // full pulse away from the idle level; n above two keeps the synchroniser fed
    task automatic pulse(input int ch, input int n);
        set_pin(ch, ~pin_o[ch]);
        repeat (n) @(posedge sys_clk_i);
        set_pin(ch, ~pin_o[ch]);
        repeat (n) @(posedge sys_clk_i);
    endtask
endmodule // tecc_pin_model

// File: test_timer_event_counter_control.sv
// test_timer_event_counter_control: self-checking bench for tecc_top.
// assumes a single-cycle register master and the pin model on the far side.
`timescale 1ns/1ps
module test_timer_event_counter_control;
    import tecc_pkg::*;
    // ************************************************************
    // stimulus, instances and shared tasks
    // ************************************************************
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic clk_en = 1'b1;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wr_data = 8'h00;
    logic [7:0] rd_data;
    logic [7:0] got;
    logic [1:0] pins;
    logic low_speed_crystal;
    logic irq;
    int fail_count = 0;
    int tests_run = 0;
    tecc_top i_dut (.sys_clk_i(sys_clk), .reset_i(reset), .clk_en_i(clk_en), .addr_i(addr),
        .wr_data_i(wr_data), .wr_en_i(wr_en), .rd_en_i(rd_en), .rd_data_o(rd_data),
        .timer_input_pin_i(pins), .low_speed_crystal_i(low_speed_crystal), .irq_o(irq));
    tecc_pin_model i_pins (.sys_clk_i(sys_clk), .pin_o(pins), .lxt_o(low_speed_crystal));
    // 250 MHz clock
    initial
    begin
        forever #2 sys_clk = ~sys_clk;
    end
    task automatic give_verdict();
        if (fail_count == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
        tests_run++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic check_in(input string what, input logic [7:0] lo, input logic [7:0] hi,
        input logic [7:0] seen);
        tests_run++;
        if ((seen >= lo && seen <= hi) !== 1'b1)
        begin
            fail_count++;
            $display("MISMATCH %s expected %h..%h seen %h", what, lo, hi, seen);
        end
    endtask
    // strobe lowered at the edge that takes it, so calls may follow at once
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge sys_clk);
        wr_en <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe; sampled once settled
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        #1 d = rd_data;
    endtask
    task automatic chk_rd(input logic [2:0] a, input logic [7:0] exp, input string what);
        rd(a, got);
        check(what, exp, got);
    endtask
    task automatic irq_is(input logic exp, input string what);
        repeat (2) @(posedge sys_clk);
        #1 check(what, {7'h0, exp}, {7'h0, irq});
    endtask
    // count advance over exactly 256 cycles between two samples
    task automatic measure(input logic [2:0] a, input logic [7:0] exp, input string what);
        logic [7:0] c0;
        logic [7:0] c1;
        rd(a, c0);
        repeat (254) @(posedge sys_clk);
        rd(a, c1);
        check(what, exp, c1 - c0);
    endtask
    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic test_reset_regs();
        for (int a = 0; a < 7; a++)
            chk_rd(3'(a), (a == 0 || a == 2) ? CTRL_RST : CNT_RST, "reset value");
        wr(3'h6, 8'hFF);
        chk_rd(3'h6, 8'h00, "unmapped read");
        wr(OFF_T1_CTRL, 8'hFF);
        chk_rd(OFF_T1_CTRL, 8'hF8, "t1 low bits");
        wr(OFF_T0_CTRL, 8'hFF);
        chk_rd(OFF_T0_CTRL, 8'hFF, "t0 all bits");
    endtask
    // preload is zero here, so wraps keep the difference exact
    task automatic test_rates();
        for (int n = 0; n < 8; n++)
        begin
            wr(OFF_T0_CTRL, 8'h90 | 8'(n));
            measure(OFF_T0_CNT, 8'(256 >> (n + 1)), "t0 prescale");
        end
        wr(OFF_T0_CTRL, 8'hB0);
        measure(OFF_T0_CNT, 8'h08, "t0 crystal");
        wr(OFF_T1_CTRL, 8'h90);
        measure(OFF_T1_CNT, 8'h40, "t1 sys over four");
        wr(OFF_T1_CTRL, 8'hB0);
        measure(OFF_T1_CNT, 8'h10, "t1 crystal");
        wr(OFF_T0_CTRL, 8'h80);
        wr(OFF_T1_CTRL, 8'h80);
    endtask
    // prescale code 7 set on purpose: pin counting must ignore it
    task automatic test_event(input logic e);
        wr(OFF_T0_CTRL, 8'h40);
        wr(OFF_T0_CNT, 8'h00);
        wr(OFF_T0_CTRL, {4'h5, e, 3'h7});
        i_pins.set_pin(0, 1'b1);
        repeat (6) @(posedge sys_clk);
        chk_rd(OFF_T0_CNT, {7'h0, ~e}, "event rise");
        i_pins.set_pin(0, 1'b0);
        repeat (6) @(posedge sys_clk);
        chk_rd(OFF_T0_CNT, 8'h01, "event fall");
    endtask
    task automatic test_gate();
        wr(OFF_T0_CTRL, 8'h47);
        i_pins.pulse(0, 4);
        chk_rd(OFF_T0_CNT, 8'h01, "run off");
        wr(OFF_T0_CTRL, 8'h17);
        i_pins.pulse(0, 4);
        repeat (20) @(posedge sys_clk);
        chk_rd(OFF_T0_CNT, 8'h01, "mode none");
    endtask
    // the second preload would never overflow in time if it loaded at once
    task automatic test_overflow();
        wr(OFF_IRQ_STS, 8'hFF);
        wr(OFF_IRQ_MSK, 8'h01);
        wr(OFF_T0_CTRL, 8'h86);
        wr(OFF_T0_CNT, 8'hFE);
        chk_rd(OFF_T0_CNT, 8'hFE, "stopped preload");
        wr(OFF_T0_CTRL, 8'h96);
        wr(OFF_T0_CNT, 8'h80);
        for (int i = 0; i < 600 && irq !== 1'b1; i++)
            @(posedge sys_clk) #1;
        check("overflow irq", 8'h01, {7'h0, irq});
        if (irq !== 1'b1)
            give_verdict();
        chk_rd(OFF_T0_CNT, 8'h80, "reload");
        chk_rd(OFF_IRQ_STS, 8'h01, "ovf status");
        wr(OFF_IRQ_MSK, 8'h00);
        irq_is(1'b0, "irq masked");
        wr(OFF_IRQ_MSK, 8'h01);
        irq_is(1'b1, "irq unmasked");
        wr(OFF_IRQ_STS, 8'h01);
        irq_is(1'b0, "irq cleared");
        wr(OFF_T0_CTRL, 8'h86);
    endtask
    // pin held active 41 cycles, about 20 ticks at divide by two
    task automatic test_capture(input logic e);
        logic [7:0] c0;
        wr(OFF_T0_CTRL, 8'h80);
        wr(OFF_T0_CNT, 8'h00);
        wr(OFF_IRQ_STS, 8'hFF);
        i_pins.set_pin(0, ~e);
        repeat (6) @(posedge sys_clk);
        wr(OFF_T0_CTRL, {4'hD, e, 3'h0});
        repeat (4) @(posedge sys_clk);
        i_pins.set_pin(0, e);
        repeat (40) @(posedge sys_clk);
        i_pins.set_pin(0, ~e);
        repeat (8) @(posedge sys_clk);
        rd(OFF_T0_CNT, c0);
        check_in("pulse width", 8'h13, 8'h16, c0);
        chk_rd(OFF_T0_CTRL, {4'hC, e, 3'h0}, "auto stop");
        chk_rd(OFF_IRQ_STS, 8'h04, "capture status");
        i_pins.pulse(0, 6);
        chk_rd(OFF_T0_CNT, c0, "after stop");
    endtask
    // main sequence
    initial
    begin
        repeat (6) @(posedge sys_clk);
        reset <= 1'b0;
        test_reset_regs();
        test_rates();
        test_event(1'b0);
        test_event(1'b1);
        test_gate();
        test_overflow();
        test_capture(1'b0);
        test_capture(1'b1);
        give_verdict();
    end
endmodule // test_timer_event_counter_control
